// >>> rtl/pmc_controller.sv
// power mode controller top: apb registers, detector, mode sequencer
`timescale 1ns/100ps
`default_nettype none

module pmc_controller
    import pmc_pkg::*;
#(
    parameter int LEVEL_W = 8,
    parameter int GATE_W = 16
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // apb slave
    input wire pmc_pkg::pmc_apb_req_type apb_req_i,
    output pmc_pkg::pmc_apb_rsp_type apb_rsp_o,
    // supply monitoring
    input wire logic supply_reset_detector_low_i,
    input wire logic [LEVEL_W-1:0] supply_level_i,
    input wire logic [8*LEVEL_W-1:0] level_table_i,
    input wire logic on_battery_i,
    // external event controller line 16 settings and output
    input wire logic line_int_en_i,
    input wire logic line_rise_en_i,
    input wire logic line_fall_en_i,
    output logic line_event_o,
    output logic line_irq_o,
    // processor core
    input wire logic wait_for_interrupt_instr_i,
    input wire logic wait_for_event_instr_i,
    input wire logic handler_exit_i,
    input wire logic irq_pending_i,
    input wire logic wakeup_event_i,
    // stop entry conditions
    input wire logic flash_busy_i,
    input wire logic bus_busy_i,
    input wire logic line_pending_i,
    input wire logic periph_pending_i,
    input wire logic alarm_flag_i,
    // stop and standby wakeups
    input wire logic line_wakeup_i,
    input wire logic wakeup_pin_i,
    input wire logic alarm_wakeup_i,
    input wire logic external_reset_pin_i,
    input wire logic independent_watchdog_reset_i,
    // power and clock controls
    output pmc_pkg::pmc_power_ctl_type power_ctl_o,
    output logic [15:0] prescale_o,
    output logic [GATE_W-1:0] periph_clk_en_o
);
    import pmc_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] scr;
        logic [31:0] clk;
        pmc_mode_type mode;
        logic entry_by_event;
        logic stop_pending;
        logic wakeup_pin_prev;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic line_irq;
        logic line_event;
        pmc_power_ctl_type pctl;
        logic [15:0] prescale;
        logic [GATE_W-1:0] gates;
    } pmc_state_type;

    pmc_state_type state_ff;
    pmc_state_type nxt_state;

    logic det_below;
    logic det_edge;
    logic wait_req;
    logic deep_sel;
    logic powerdown_deep_select_sel;
    logic stop_blocked;
    logic wakeup_rise;
    logic exit_reset;
    logic apb_access;
    logic [31:0] status_word;

    // ****************************************
    // detector
    // ****************************************
    pmc_detector #(
        .LEVEL_W(LEVEL_W)
    ) u_detector (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .supply_level_i(supply_level_i),
        .level_table_i(level_table_i),
        .enable_i(state_ff.ctrl[PMC_CTRL_DET_EN_BIT]),
        .thr_sel_i(state_ff.ctrl[PMC_CTRL_THR_LSB +: 3]),
        .rise_en_i(line_rise_en_i),
        .fall_en_i(line_fall_en_i),
        .below_o(det_below),
        .edge_o(det_edge)
    );

    // ****************************************
    // helper terms
    // ****************************************
    assign wait_req = wait_for_interrupt_instr_i || wait_for_event_instr_i
        || (handler_exit_i && state_ff.scr[PMC_SCR_ON_EXIT_BIT]);
    assign deep_sel = state_ff.scr[PMC_SCR_DEEP_BIT];
    assign powerdown_deep_select_sel = state_ff.ctrl[PMC_CTRL_POWERDOWN_DEEP_SELECT_BIT];
    assign stop_blocked = line_pending_i || periph_pending_i || alarm_flag_i;
    assign wakeup_rise = wakeup_pin_i && !state_ff.wakeup_pin_prev;
    assign exit_reset = wakeup_rise || alarm_wakeup_i || external_reset_pin_i
        || independent_watchdog_reset_i;
    assign apb_access = apb_req_i.psel && apb_req_i.penable && !state_ff.pready;

    // status word: below flag and current mode
    always_comb begin
        status_word = '0;
        status_word[PMC_STAT_BELOW_BIT] = det_below;
        status_word[PMC_STAT_MODE_LSB +: 2] = state_ff.mode;
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_state.pready = 1'b0;
        nxt_state.pslverr = 1'b0;
        nxt_state.wakeup_pin_prev = wakeup_pin_i;

        // apb access: one wait state, answer registered
        if (apb_access) begin
            nxt_state.pready = 1'b1;
            nxt_state.prdata = '0;
            unique case (apb_req_i.paddr)
                PMC_CTRL_OFFS: begin
                    if (apb_req_i.pwrite) begin
                        nxt_state.ctrl = apb_req_i.pwdata;
                    end
                    nxt_state.prdata = state_ff.ctrl;
                end
                PMC_STAT_OFFS: begin
                    nxt_state.prdata = status_word;
                end
                PMC_SCR_OFFS: begin
                    if (apb_req_i.pwrite) begin
                        nxt_state.scr = apb_req_i.pwdata;
                    end
                    nxt_state.prdata = state_ff.scr;
                end
                PMC_CLK_OFFS: begin
                    if (apb_req_i.pwrite) begin
                        nxt_state.clk = apb_req_i.pwdata;
                    end
                    nxt_state.prdata = state_ff.clk;
                end
                default: begin
                    nxt_state.pslverr = 1'b1;
                end
            endcase
        end

        // event line 16 from the detector
        nxt_state.line_event = det_edge;
        nxt_state.line_irq = det_edge && line_int_en_i;

        // mode sequencer
        unique case (state_ff.mode)
            PMC_MODE_RUN: begin
                nxt_state.stop_pending = 1'b0;
                if (wait_req || state_ff.stop_pending) begin
                    nxt_state.entry_by_event = wait_for_event_instr_i;
                    if (!deep_sel) begin
                        nxt_state.mode = PMC_MODE_SLEEP;
                    end else if (powerdown_deep_select_sel) begin
                        nxt_state.mode = PMC_MODE_STANDBY;
                    end else if (stop_blocked) begin
                        nxt_state.mode = PMC_MODE_RUN;
                    end else if (flash_busy_i || bus_busy_i) begin
                        nxt_state.stop_pending = 1'b1;
                    end else begin
                        nxt_state.mode = PMC_MODE_STOP;
                    end
                end
            end
            PMC_MODE_SLEEP: begin
                if (state_ff.entry_by_event ? wakeup_event_i : irq_pending_i) begin
                    nxt_state.mode = PMC_MODE_RUN;
                end
            end
            PMC_MODE_STOP: begin
                if (line_wakeup_i) begin
                    nxt_state.mode = PMC_MODE_RUN;
                end
            end
            PMC_MODE_STANDBY: begin
                // leave only through the reset sequence
                if (exit_reset) begin
                    nxt_state.mode = PMC_MODE_RUN;
                end
            end
        endcase

        // power and clock controls follow the next mode
        nxt_state.pctl.cpu_clk_en = (nxt_state.mode == PMC_MODE_RUN);
        nxt_state.pctl.core_clk_en = (nxt_state.mode == PMC_MODE_RUN)
            || (nxt_state.mode == PMC_MODE_SLEEP);
        nxt_state.pctl.tick_clk_en = (nxt_state.mode != PMC_MODE_STANDBY);
        nxt_state.pctl.int_osc_en = nxt_state.pctl.core_clk_en;
        nxt_state.pctl.ext_osc_en = nxt_state.pctl.core_clk_en;
        if (state_ff.mode == PMC_MODE_STOP && nxt_state.mode == PMC_MODE_RUN) begin
            nxt_state.pctl.int_osc_select = 1'b1;
        end else if (apb_access && apb_req_i.pwrite && apb_req_i.paddr == PMC_CLK_OFFS) begin
            nxt_state.pctl.int_osc_select = 1'b0;
        end
        nxt_state.pctl.reg_on = (nxt_state.mode != PMC_MODE_STANDBY);
        nxt_state.pctl.reg_low_power = (nxt_state.mode == PMC_MODE_STOP);
        nxt_state.pctl.chip_reset = supply_reset_detector_low_i
            || (state_ff.mode == PMC_MODE_STANDBY && exit_reset);
        nxt_state.pctl.crystal_pins_locked = on_battery_i;

        // prescalers and gates; gates hold through sleep
        nxt_state.prescale = nxt_state.clk[PMC_CLK_PRE_LSB +: 16];
        nxt_state.gates = nxt_state.clk[PMC_CLK_GATE_LSB +: GATE_W]
            & {GATE_W{nxt_state.pctl.core_clk_en}};
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i || supply_reset_detector_low_i) begin
            state_ff <= '0;
            state_ff.ctrl <= PMC_CTRL_RESET;
            state_ff.scr <= PMC_SCR_RESET;
            state_ff.clk <= PMC_CLK_RESET;
            state_ff.mode <= PMC_MODE_RUN;
            state_ff.pctl <= PMC_PCTL_RESET;
            state_ff.gates <= PMC_CLK_RESET[PMC_CLK_GATE_LSB +: GATE_W];
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign apb_rsp_o.pready = state_ff.pready;
    assign apb_rsp_o.pslverr = state_ff.pslverr;
    assign apb_rsp_o.prdata = state_ff.prdata;
    assign line_event_o = state_ff.line_event;
    assign line_irq_o = state_ff.line_irq;
    assign power_ctl_o = state_ff.pctl;
    assign prescale_o = state_ff.prescale;
    assign periph_clk_en_o = state_ff.gates;

endmodule : pmc_controller

`default_nettype wire

// >>> rtl/pmc_pkg.sv
// package of constants and types for the power mode controller
package pmc_pkg;

    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam logic [11:0] PMC_CTRL_OFFS = 12'h000; // power_control_register
    localparam logic [11:0] PMC_STAT_OFFS = 12'h004; // power_status_register
    localparam logic [11:0] PMC_SCR_OFFS = 12'h008; // core system control bits
    localparam logic [11:0] PMC_CLK_OFFS = 12'h00C; // prescalers and clock gates

    // ****************************************
    // control register fields
    // ****************************************
    localparam int PMC_CTRL_POWERDOWN_DEEP_SELECT_BIT = 1;
    localparam int PMC_CTRL_DET_EN_BIT = 4;
    localparam int PMC_CTRL_THR_LSB = 5;
    localparam logic [31:0] PMC_CTRL_RESET = 32'h0000_0000;

    // ****************************************
    // status register fields
    // ****************************************
    localparam int PMC_STAT_BELOW_BIT = 2;
    localparam int PMC_STAT_MODE_LSB = 4;

    // ****************************************
    // core system control fields
    // ****************************************
    localparam int PMC_SCR_ON_EXIT_BIT = 1;
    localparam int PMC_SCR_DEEP_BIT = 2;
    localparam logic [31:0] PMC_SCR_RESET = 32'h0000_0000;

    // ****************************************
    // clock register fields
    // ****************************************
    localparam int PMC_CLK_PRE_LSB = 0;
    localparam int PMC_CLK_GATE_LSB = 16;
    localparam logic [31:0] PMC_CLK_RESET = 32'hFFFF_0000;
    localparam logic [9:0] PMC_PCTL_RESET = 10'h3FA; // all on, chip held in reset

    // ****************************************
    // detector and event line constants
    // ****************************************
    localparam int PMC_DET_EVENT_LINE = 16;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        PMC_MODE_RUN,
        PMC_MODE_SLEEP,
        PMC_MODE_STOP,
        PMC_MODE_STANDBY
    } pmc_mode_type;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pmc_apb_req_type;

    // apb answer to the master
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } pmc_apb_rsp_type;

    // clock and power controls toward the chip
    typedef struct packed {
        logic cpu_clk_en;
        logic core_clk_en;
        logic tick_clk_en;
        logic int_osc_en;
        logic ext_osc_en;
        logic int_osc_select;
        logic reg_on;
        logic reg_low_power;
        logic chip_reset;
        logic crystal_pins_locked;
    } pmc_power_ctl_type;

endpackage : pmc_pkg

// >>> rtl/pmc_detector.sv
// low voltage detector comparison and event line edge logic
`timescale 1ns/100ps
`default_nettype none

module pmc_detector
    import pmc_pkg::*;
#(
    parameter int LEVEL_W = 8
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // supply measurement and levels
    input wire logic [LEVEL_W-1:0] supply_level_i,
    input wire logic [8*LEVEL_W-1:0] level_table_i,
    // configuration
    input wire logic enable_i,
    input wire logic [2:0] thr_sel_i,
    input wire logic rise_en_i,
    input wire logic fall_en_i,
    // results
    output logic below_o,
    output logic edge_o
);
    import pmc_pkg::*;

    typedef struct packed {
        logic below;
        logic edge_seen;
    } pmc_det_state_type;

    pmc_det_state_type state_ff;
    pmc_det_state_type nxt_state;
    logic [LEVEL_W-1:0] level_sel;

    // compare supply to selected level
    always_comb begin
        level_sel = level_table_i[thr_sel_i*LEVEL_W +: LEVEL_W];
        nxt_state = state_ff;
        nxt_state.edge_seen = 1'b0;
        if (!enable_i) begin
            nxt_state.below = 1'b0;
        end else begin
            nxt_state.below = (supply_level_i < level_sel);
            // falling supply sets below, rising clears it
            if (nxt_state.below && !state_ff.below && fall_en_i) begin
                nxt_state.edge_seen = 1'b1;
            end
            if (!nxt_state.below && state_ff.below && rise_en_i) begin
                nxt_state.edge_seen = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign below_o = state_ff.below;
    assign edge_o = state_ff.edge_seen;

endmodule : pmc_detector

`default_nettype wire

// >>> tb/pmc_controller_chk.sv
// concurrent checks on the power mode controller ports
`timescale 1ns/100ps
`default_nettype none

module pmc_controller_chk
    import pmc_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // apb
    input wire pmc_pkg::pmc_apb_req_type apb_req_i,
    input wire pmc_pkg::pmc_apb_rsp_type apb_rsp_o,
    // watched inputs
    input wire logic supply_reset_detector_low_i,
    input wire logic on_battery_i,
    input wire logic flash_busy_i,
    input wire logic bus_busy_i,
    input wire logic line_pending_i,
    input wire logic periph_pending_i,
    input wire logic alarm_flag_i,
    // watched outputs
    input wire logic line_event_o,
    input wire logic line_irq_o,
    input wire pmc_pkg::pmc_power_ctl_type power_ctl_o
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    // access phase waiting for its answer
    sequence s_access;
        apb_req_i.psel && apb_req_i.penable && !apb_rsp_o.pready;
    endsequence
    // one-cycle answer
    sequence s_answer;
        apb_rsp_o.pready ##1 !apb_rsp_o.pready;
    endsequence

    a_apb_answer: assert property (s_access |=> s_answer)
        else $error("apb answer late or too long");
    a_run_after_reset: assert property ($rose(reset_n_i) |-> power_ctl_o.reg_on
        && power_ctl_o.cpu_clk_en && power_ctl_o.core_clk_en) else $error("not run after reset");
    a_low_supply_hold: assert property (supply_reset_detector_low_i |=>
        power_ctl_o.chip_reset) else $error("chip not held in reset");
    a_sleep_clocks: assert property (!power_ctl_o.cpu_clk_en && power_ctl_o.core_clk_en
        |-> power_ctl_o.tick_clk_en && power_ctl_o.reg_on && !power_ctl_o.reg_low_power)
        else $error("sleep clocks wrong");
    a_stop_clocks: assert property (!power_ctl_o.core_clk_en && power_ctl_o.reg_on
        |-> power_ctl_o.reg_low_power && power_ctl_o.tick_clk_en && !power_ctl_o.cpu_clk_en
        && !power_ctl_o.int_osc_en && !power_ctl_o.ext_osc_en) else $error("bad stop state");
    a_standby_off: assert property (!power_ctl_o.reg_on |-> !power_ctl_o.core_clk_en
        && !power_ctl_o.int_osc_en && !power_ctl_o.ext_osc_en) else $error("bad standby state");
    a_busy_postpone: assert property ((flash_busy_i || bus_busy_i) && power_ctl_o.core_clk_en
        |=> power_ctl_o.core_clk_en || !power_ctl_o.reg_on) else $error("stop while busy");
    a_pending_skip: assert property ((line_pending_i || periph_pending_i || alarm_flag_i)
        && power_ctl_o.core_clk_en |=> power_ctl_o.core_clk_en || !power_ctl_o.reg_on)
        else $error("stop despite pending");
    a_stop_exit_osc: assert property ($rose(power_ctl_o.core_clk_en)
        && $past(power_ctl_o.reg_on) |-> power_ctl_o.int_osc_select)
        else $error("stop exit osc");
    a_irq_gated: assert property (line_irq_o |-> line_event_o)
        else $error("interrupt without line event");
    a_battery_lock: assert property (on_battery_i |=> power_ctl_o.crystal_pins_locked)
        else $error("pins not locked");
endmodule : pmc_controller_chk

bind pmc_controller pmc_controller_chk i_pmc_controller_chk (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .apb_req_i(apb_req_i),
    .apb_rsp_o(apb_rsp_o), .supply_reset_detector_low_i(supply_reset_detector_low_i),
    .on_battery_i(on_battery_i), .flash_busy_i(flash_busy_i), .bus_busy_i(bus_busy_i),
    .line_pending_i(line_pending_i), .periph_pending_i(periph_pending_i),
    .alarm_flag_i(alarm_flag_i), .line_event_o(line_event_o), .line_irq_o(line_irq_o),
    .power_ctl_o(power_ctl_o)
);

`default_nettype wire

// >>> tb/pmc_core_model.sv
// processor core and interrupt controller model: wait pulses, pending, events
`timescale 1ns/100ps
`default_nettype none

module pmc_core_model (
    // clock
    input wire logic core_clk_i,
    // toward the controller
    output var logic wfi_o,
    output var logic wfe_o,
    output var logic irq_pending_o,
    output var logic wakeup_event_o
);
    // idle at time zero
    initial {wfi_o, wfe_o, irq_pending_o, wakeup_event_o} = 4'h0;

    // one-cycle wait instruction of either kind
    task issue(input logic use_event);
        @(posedge core_clk_i);
        wfe_o <= use_event;
        wfi_o <= !use_event;
        @(posedge core_clk_i);
        wfe_o <= 1'b0;
        wfi_o <= 1'b0;
    endtask : issue

    // pending interrupt level
    task set_irq(input logic v);
        @(posedge core_clk_i) irq_pending_o <= v;
    endtask : set_irq

    // single wakeup event pulse
    task pulse_event;
        @(posedge core_clk_i) wakeup_event_o <= 1'b1;
        @(posedge core_clk_i) wakeup_event_o <= 1'b0;
    endtask : pulse_event
endmodule : pmc_core_model

`default_nettype wire

// >>> tb/pmc_controller_test.sv
// self-checking bench for the power mode controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin fails++; \
    $display("BAD %s expected %h seen %h", nm, ex, got); end end

module pmc_controller_test;
    import pmc_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    typedef struct {logic [2:0] thr; logic [7:0] lvl; logic below;} pmc_row_type;
    typedef struct {logic en; logic rise; logic fall; logic ien; int ev, irq;} pmc_edge_type;
    logic core_clk, reset_n, supply_low, on_battery, int_en, rise_en, fall_en, err;
    logic event_out, irq_out, wait_for_interrupt_instr, wait_for_event_instr, irq_pend, wake_ev, bus_busy, line_wake, wake_pin;
    logic fbusy, alarm_wk, ext_rst;
    logic [2:0] pend;
    logic [7:0] supply;
    logic [63:0] table_lev;
    logic [15:0] prescale, gates;
    logic [31:0] rd;
    pmc_apb_req_type apb_req;
    pmc_apb_rsp_type apb_rsp;
    pmc_power_ctl_type pwr;
    int fails, num_checks, ev_cnt, irq_cnt;
    pmc_row_type rows[16];
    pmc_edge_type edges[4] = '{'{1, 0, 1, 1, 1, 1}, '{1, 1, 0, 0, 1, 0},
        '{1, 1, 1, 1, 2, 2}, '{0, 1, 1, 1, 0, 0}};

    pmc_controller i_pmc_controller (
        .core_clk_i(core_clk), .reset_n_i(reset_n), .apb_req_i(apb_req), .apb_rsp_o(apb_rsp),
        .supply_reset_detector_low_i(supply_low), .supply_level_i(supply),
        .level_table_i(table_lev), .on_battery_i(on_battery), .line_int_en_i(int_en),
        .line_rise_en_i(rise_en), .line_fall_en_i(fall_en), .line_event_o(event_out),
        .line_irq_o(irq_out), .wait_for_interrupt_instr_i(wait_for_interrupt_instr), .wait_for_event_instr_i(wait_for_event_instr),
        .handler_exit_i(1'b0), .irq_pending_i(irq_pend), .wakeup_event_i(wake_ev),
        .flash_busy_i(fbusy), .bus_busy_i(bus_busy), .line_pending_i(pend[2]),
        .periph_pending_i(pend[1]), .alarm_flag_i(pend[0]), .line_wakeup_i(line_wake),
        .wakeup_pin_i(wake_pin), .alarm_wakeup_i(alarm_wk), .external_reset_pin_i(ext_rst),
        .independent_watchdog_reset_i(1'b0), .power_ctl_o(pwr), .prescale_o(prescale),
        .periph_clk_en_o(gates)
    );
    pmc_core_model i_pmc_core_model (.core_clk_i(core_clk), .wfi_o(wait_for_interrupt_instr), .wfe_o(wait_for_event_instr),
        .irq_pending_o(irq_pend), .wakeup_event_o(wake_ev));

    // clock and event counters
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (event_out === 1'b1) ev_cnt++;
        if (irq_out === 1'b1) irq_cnt++;
    end

    // ****************************************
    // tasks
    // ****************************************
    task step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step

    // one apb transfer, waiting for pready
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
    endtask : apb

    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    // watchdog against a hang
    initial begin
        repeat (30000) @(posedge core_clk);
        fails++;
        report_and_stop();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {reset_n, supply_low, on_battery, int_en, rise_en, fall_en} = 6'h00;
        {bus_busy, line_wake, wake_pin, pend, fbusy, alarm_wk, ext_rst} = 9'h000;
        apb_req = '0;
        supply = 8'h80;
        {fails, num_checks, ev_cnt, irq_cnt} = '0;
        for (int n = 0; n < 8; n++) begin
            table_lev[n*8 +: 8] = 8'h20 + 8'(n * 24);
            rows[2*n] = '{3'(n), 8'h1B + 8'(n * 24), 1'b1};
            rows[2*n+1] = '{3'(n), 8'h25 + 8'(n * 24), 1'b0};
        end
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        step(1);
        // reset values, read-only status, unmapped place
        `CHK("pwr", 10'h3F8, pwr)
        `CHK("gates", 16'hFFFF, gates)
        apb(1'b0, PMC_CTRL_OFFS, 32'h0000_0000);
        `CHK("ctrl", PMC_CTRL_RESET, rd)
        apb(1'b0, PMC_SCR_OFFS, 32'h0000_0000);
        `CHK("scr", PMC_SCR_RESET, rd)
        apb(1'b1, PMC_STAT_OFFS, 32'hFFFF_FFFF);
        apb(1'b0, PMC_STAT_OFFS, 32'h0000_0000);
        `CHK("mode", 2'b00, rd[5:4])
        apb(1'b0, 12'h010, 32'h0000_0000);
        `CHK("slverr", 1'b1, err)
        `CHK("rdata", 32'h0000_0000, rd)
        // threshold select rows
        foreach (rows[i]) begin
            @(posedge core_clk) supply <= rows[i].lvl;
            apb(1'b1, PMC_CTRL_OFFS, (32'(1) << PMC_CTRL_DET_EN_BIT)
                | (32'(rows[i].thr) << PMC_CTRL_THR_LSB));
            step(3);
            apb(1'b0, PMC_STAT_OFFS, 32'h0000_0000);
            `CHK("below", rows[i].below, rd[PMC_STAT_BELOW_BIT])
        end
        // edge selections and the line enable
        foreach (edges[i]) begin
            @(posedge core_clk) supply <= 8'h80;
            {rise_en, fall_en, int_en} <= {edges[i].rise, edges[i].fall, edges[i].ien};
            apb(1'b1, PMC_CTRL_OFFS, 32'(edges[i].en) << PMC_CTRL_DET_EN_BIT);
            step(4);
            {ev_cnt, irq_cnt} = '0;
            @(posedge core_clk) supply <= 8'h10;
            step(6);
            apb(1'b0, PMC_STAT_OFFS, 32'h0000_0000);
            `CHK("below", edges[i].en, rd[PMC_STAT_BELOW_BIT])
            @(posedge core_clk) supply <= 8'h80;
            step(6);
            `CHK("events", edges[i].ev, ev_cnt)
            `CHK("irqs", edges[i].irq, irq_cnt)
        end
        // prescalers and clock gates
        apb(1'b1, PMC_CLK_OFFS, 32'h00F0_0003);
        step(2);
        `CHK("prescale", 16'h0003, prescale)
        `CHK("gates", 16'h00F0, gates)
        // sleep by interrupt wait, then by event wait
        apb(1'b1, PMC_SCR_OFFS, 32'h0000_0000);
        for (int k = 0; k < 2; k++) begin
            i_pmc_core_model.issue(k[0]);
            step(3);
            `CHK("sleep", 3'b011, {pwr.cpu_clk_en, pwr.core_clk_en, pwr.tick_clk_en})
            `CHK("gates", 16'h00F0, gates)
            apb(1'b0, PMC_STAT_OFFS, 32'h0000_0000);
            `CHK("mode", 2'b01, rd[5:4])
            i_pmc_core_model.set_irq(1'b1);
            step(3);
            `CHK("cpu_clk", !k[0], pwr.cpu_clk_en)
            i_pmc_core_model.set_irq(1'b0);
            i_pmc_core_model.pulse_event;
            step(3);
            `CHK("cpu_clk", 1'b1, pwr.cpu_clk_en)
        end
        // stop postponed by bus access and flash programming, then line wakeup
        apb(1'b1, PMC_SCR_OFFS, 32'(1) << PMC_SCR_DEEP_BIT);
        apb(1'b1, PMC_CTRL_OFFS, 32'h0000_0000);
        @(posedge core_clk) {bus_busy, fbusy} <= 2'b11;
        i_pmc_core_model.issue(1'b0);
        step(4);
        `CHK("core_clk", 1'b1, pwr.core_clk_en)
        @(posedge core_clk) bus_busy <= 1'b0;
        step(3);
        `CHK("core_clk", 1'b1, pwr.core_clk_en)
        @(posedge core_clk) fbusy <= 1'b0;
        step(3);
        `CHK("stop", 10'h08C, pwr)
        @(posedge core_clk) line_wake <= 1'b1;
        step(3);
        `CHK("exit", 2'b11, {pwr.core_clk_en, pwr.int_osc_select})
        @(posedge core_clk) line_wake <= 1'b0;
        // each pending flag refuses stop
        for (int k = 0; k < 3; k++) begin
            @(posedge core_clk) pend <= 3'b001 << k;
            i_pmc_core_model.issue(1'b0);
            step(3);
            `CHK("core_clk", 1'b1, pwr.core_clk_en)
            @(posedge core_clk) pend <= 3'b000;
        end
        // standby, left by wakeup pin, alarm and external reset in turn
        apb(1'b1, PMC_CTRL_OFFS, 32'(1) << PMC_CTRL_POWERDOWN_DEEP_SELECT_BIT);
        for (int k = 0; k < 3; k++) begin
            i_pmc_core_model.issue(1'b0);
            step(3);
            `CHK("standby", 10'h010, pwr)
            @(posedge core_clk) {ext_rst, alarm_wk, wake_pin} <= 3'b001 << k;
            step(4);
            `CHK("woken", 10'h3F8, pwr)
            @(posedge core_clk) {ext_rst, alarm_wk, wake_pin} <= 3'b000;
        end
        // low supply holds the chip in reset
        @(posedge core_clk) supply_low <= 1'b1;
        step(2);
        `CHK("chip_reset", 1'b1, pwr.chip_reset)
        @(posedge core_clk) supply_low <= 1'b0;
        step(2);
        `CHK("chip_reset", 1'b0, pwr.chip_reset)
        apb(1'b0, PMC_CLK_OFFS, 32'h0000_0000);
        `CHK("clk", PMC_CLK_RESET, rd)
        // crystal pins on battery
        @(posedge core_clk) on_battery <= 1'b1;
        step(2);
        `CHK("locked", 1'b1, pwr.crystal_pins_locked)
        @(posedge core_clk) on_battery <= 1'b0;
        step(2);
        `CHK("locked", 1'b0, pwr.crystal_pins_locked)
        report_and_stop();
    end
endmodule : pmc_controller_test

`default_nettype wire
